// ===== rtl/aoc_pkg.sv
// package: constants and types for the alarm output conditioner
`default_nettype none
package aoc_pkg;
  localparam int unsigned NUM_ALARMS = 4;
  localparam int unsigned NUM_EVENTS = 6;
  localparam int unsigned TYPE_W = 5;
  localparam int unsigned DELAY_W = 10;
  localparam int unsigned LEVEL_W = 3;
  // alarm type codes that gate the latch and delay features
  localparam logic [4:0] TYPE_NONE = 5'h00;
  localparam logic [4:0] TYPE_LOOP_BREAK = 5'h0c;
  localparam logic [4:0] TYPE_EXCLUDED_13 = 5'h0d;
  // greatest delay setting in seconds
  localparam logic [9:0] DELAY_MAX_S = 10'h3e7;
  // operating levels; the setup levels force latched outputs off
  localparam logic [2:0] LVL_OPERATION = 3'h0;
  localparam logic [2:0] LVL_ADJUST = 3'h1;
  localparam logic [2:0] LVL_INITIAL = 3'h2;
  localparam logic [2:0] LVL_COMMS = 3'h3;
  localparam logic [2:0] LVL_ADVANCED = 3'h4;
  localparam logic [2:0] LVL_CALIBRATION = 3'h5;
  // one-second prescaler at a 200 MHz clock
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned TICK_W = 28;
  localparam logic [27:0] TICK_RESET = 28'h0000000;
  localparam logic [9:0] DELAY_RESET = 10'h000;
  // per-alarm delay states
  typedef enum logic [3:0] {
    AOC_IDLE = 4'b0001,
    AOC_ON_WAIT = 4'b0010,
    AOC_ACTIVE = 4'b0100,
    AOC_OFF_WAIT = 4'b1000
  } aoc_dly_state_t;
endpackage
`default_nettype wire

// ===== rtl/aoc_delay_if.sv
// interface: one alarm's delay channel between top and delay unit
`default_nettype none
interface aoc_delay_if;
  logic cond;
  logic enable;
  logic [9:0] on_delay;
  logic [9:0] off_delay;
  logic delayed;
  modport ctrl (output cond, output enable, output on_delay, output off_delay, input delayed);
  modport unit (input cond, input enable, input on_delay, input off_delay, output delayed);
endinterface
`default_nettype wire

// ===== rtl/aoc_delay_unit.sv
// module: ON and OFF delay timer for one alarm
`default_nettype none
module aoc_delay_unit (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  aoc_delay_if.unit ch
);
  aoc_pkg::aoc_dly_state_t state_q;
  aoc_pkg::aoc_dly_state_t state_d;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;

  // next state: a zero setting skips the wait entirely
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (!ch.enable)
    begin
      state_d = ch.cond ? aoc_pkg::AOC_ACTIVE : aoc_pkg::AOC_IDLE;
      cnt_d = aoc_pkg::DELAY_RESET;
    end
    else
    begin
      case (state_q)
        aoc_pkg::AOC_IDLE:
        begin
          cnt_d = aoc_pkg::DELAY_RESET;
          if (ch.cond && ch.on_delay == aoc_pkg::DELAY_RESET)
            state_d = aoc_pkg::AOC_ACTIVE;
          else if (ch.cond)
            state_d = aoc_pkg::AOC_ON_WAIT;
        end
        aoc_pkg::AOC_ON_WAIT:
        begin
          if (!ch.cond)
          begin
            state_d = aoc_pkg::AOC_IDLE;
            cnt_d = aoc_pkg::DELAY_RESET;
          end
          else if (tick)
          begin
            // one count past the setting: the first tick lands part-way into a second
            cnt_d = cnt_q + 10'h001;
            if (cnt_d > ch.on_delay)
            begin
              state_d = aoc_pkg::AOC_ACTIVE;
              cnt_d = aoc_pkg::DELAY_RESET;
            end
          end
        end
        aoc_pkg::AOC_ACTIVE:
        begin
          cnt_d = aoc_pkg::DELAY_RESET;
          if (!ch.cond && ch.off_delay == aoc_pkg::DELAY_RESET)
            state_d = aoc_pkg::AOC_IDLE;
          else if (!ch.cond)
            state_d = aoc_pkg::AOC_OFF_WAIT;
        end
        aoc_pkg::AOC_OFF_WAIT:
        begin
          if (ch.cond)
          begin
            state_d = aoc_pkg::AOC_ACTIVE;
            cnt_d = aoc_pkg::DELAY_RESET;
          end
          else if (tick)
          begin
            // one count past the setting so a full off delay always elapses
            cnt_d = cnt_q + 10'h001;
            if (cnt_d > ch.off_delay)
            begin
              state_d = aoc_pkg::AOC_IDLE;
              cnt_d = aoc_pkg::DELAY_RESET;
            end
          end
        end
        default:
        begin
          state_d = aoc_pkg::AOC_IDLE;
          cnt_d = aoc_pkg::DELAY_RESET;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= aoc_pkg::AOC_IDLE;
      cnt_q <= aoc_pkg::DELAY_RESET;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // output holds through the off wait, stays low through the on wait
  assign ch.delayed = (state_q == aoc_pkg::AOC_ACTIVE) || (state_q == aoc_pkg::AOC_OFF_WAIT);

  property p_on_wait_low;
    @(posedge clock) disable iff (!rst_n)
    (state_q == aoc_pkg::AOC_IDLE && ch.enable && ch.cond && ch.on_delay != 10'h000)
      |=> !ch.delayed;
  endproperty
  a_on_wait_low: assert property (p_on_wait_low) else $error("on delay not honoured");

  property p_zero_on;
    @(posedge clock) disable iff (!rst_n)
    (state_q == aoc_pkg::AOC_IDLE && ch.cond && (ch.on_delay == 10'h000 || !ch.enable))
      |=> ch.delayed;
  endproperty
  a_zero_on: assert property (p_zero_on) else $error("zero on delay waited");

  property p_off_wait_high;
    @(posedge clock) disable iff (!rst_n)
    (state_q == aoc_pkg::AOC_ACTIVE && ch.enable && !ch.cond && ch.off_delay != 10'h000)
      |=> ch.delayed;
  endproperty
  a_off_wait_high: assert property (p_off_wait_high) else $error("off delay not honoured");

  property p_zero_off;
    @(posedge clock) disable iff (!rst_n)
    (state_q == aoc_pkg::AOC_ACTIVE && !ch.cond && (ch.off_delay == 10'h000 || !ch.enable))
      |=> !ch.delayed;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero off delay waited");

  property p_restart;
    @(posedge clock) disable iff (!rst_n)
    (state_q == aoc_pkg::AOC_ON_WAIT && !ch.cond) |=> (state_q == aoc_pkg::AOC_IDLE);
  endproperty
  a_restart: assert property (p_restart) else $error("on wait not restarted");

  c_on_wait: cover property (@(posedge clock) state_q == aoc_pkg::AOC_ON_WAIT ##1
    state_q == aoc_pkg::AOC_ACTIVE);
  c_off_wait: cover property (@(posedge clock) state_q == aoc_pkg::AOC_OFF_WAIT ##1
    state_q == aoc_pkg::AOC_IDLE);
endmodule
`default_nettype wire

// ===== rtl/aoc_top.sv
// module: alarm output conditioner top with latch, level forcing and polarity
`default_nettype none
// Contract
// - with hold enabled, an alarm stays asserted after its condition clears
// - function key set to latch cancel clears every held latch
// - any of six event inputs set to latch cancel clears latches
// - reset (power cycle) starts every latch inactive
// - entering initial, comms, advanced or calibration level forces latched outputs off
// - while held, close-in-alarm output stays closed, open-in-alarm stays open
// - hold applies to alarm 1 if type nonzero, alarms 2-4 if not 0 or 12
// - output stays inactive until the ON delay expires after condition rises
// - ON delay of zero asserts the output without waiting
// - output stays active until the OFF delay expires after condition falls
// - OFF delay of zero deasserts the output without waiting
// - delays apply only when assigned and type is not 0, 12 or 13
module aoc_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] alarm_cond,
  input wire logic [3:0] alarm_assigned,
  input wire logic [19:0] alarm_type,
  input wire logic alarm1_hold_enable,
  input wire logic alarm2_hold_enable,
  input wire logic alarm3_hold_enable,
  input wire logic alarm4_hold_enable,
  input wire logic [39:0] on_delay_s,
  input wire logic [39:0] off_delay_s,
  input wire logic [3:0] open_in_alarm,
  input wire logic function_key,
  input wire logic function_key_is_latch_cancel_function,
  input wire logic [5:0] event_in,
  input wire logic [5:0] event_is_latch_cancel_function,
  input wire logic [2:0] operating_level,
  output logic [3:0] aux_out,
  output logic [3:0] alarm_state
);
  logic rst_meta_q;
  logic rst_n_q;
  logic [3:0] cond_s1_q;
  logic [3:0] cond_s2_q;
  logic key_s1_q;
  logic key_s2_q;
  logic key_prev_q;
  logic [5:0] ev_s1_q;
  logic [5:0] ev_s2_q;
  logic [5:0] ev_prev_q;
  logic [27:0] tick_cnt_q;
  logic [27:0] tick_cnt_d;
  logic tick;
  logic [3:0] hold_en;
  logic [3:0] hold_ok;
  logic [3:0] dly_ok;
  logic [3:0] delayed;
  logic [3:0] latch_q;
  logic [3:0] latch_d;
  logic [3:0] state_d;
  logic [3:0] state_q;
  logic [3:0] aux_d;
  logic [3:0] aux_q;
  logic [2:0] level_q;
  logic cancel;
  logic setup_level;
  logic level_entry;

  // ------------------------------------------------------------
  // reset and input synchronisers
  // ------------------------------------------------------------

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // pin synchronisers; the second stage feeds logic, plus the key and event edge-detect flops behind it
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cond_s1_q <= 4'h0;
      cond_s2_q <= 4'h0;
      key_s1_q <= 1'b0;
      key_s2_q <= 1'b0;
      key_prev_q <= 1'b0;
      ev_s1_q <= 6'h00;
      ev_s2_q <= 6'h00;
      ev_prev_q <= 6'h00;
    end
    else
    begin
      cond_s1_q <= alarm_cond;
      cond_s2_q <= cond_s1_q;
      key_s1_q <= function_key;
      key_s2_q <= key_s1_q;
      key_prev_q <= key_s2_q;
      ev_s1_q <= event_in;
      ev_s2_q <= ev_s1_q;
      ev_prev_q <= ev_s2_q;
    end
  end

  // ------------------------------------------------------------
  // one-second timing
  // ------------------------------------------------------------

  always_comb
  begin
    tick = (tick_cnt_q == 28'(aoc_pkg::TICK_CYCLES - 1));
    tick_cnt_d = tick ? aoc_pkg::TICK_RESET : tick_cnt_q + 28'h0000001;
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      tick_cnt_q <= aoc_pkg::TICK_RESET;
    else
      tick_cnt_q <= tick_cnt_d;
  end

  // ------------------------------------------------------------
  // alarm conditioning
  // ------------------------------------------------------------

  always_comb
  begin
    hold_en = {alarm4_hold_enable, alarm3_hold_enable, alarm2_hold_enable, alarm1_hold_enable};
    for (int i = 0; i < 4; i++)
    begin
      if (i == 0)
        hold_ok[i] = alarm_assigned[i] && hold_en[i] && (alarm_type[i*5 +: 5] != aoc_pkg::TYPE_NONE);
      else
        hold_ok[i] = alarm_assigned[i] && hold_en[i]
          && (alarm_type[i*5 +: 5] != aoc_pkg::TYPE_NONE)
          && (alarm_type[i*5 +: 5] != aoc_pkg::TYPE_LOOP_BREAK);
      dly_ok[i] = alarm_assigned[i]
        && (alarm_type[i*5 +: 5] != aoc_pkg::TYPE_NONE)
        && (alarm_type[i*5 +: 5] != aoc_pkg::TYPE_LOOP_BREAK)
        && (alarm_type[i*5 +: 5] != aoc_pkg::TYPE_EXCLUDED_13);
    end
  end

  // per-alarm delay units
  for (genvar g = 0; g < 4; g++)
  begin : g_dly
    aoc_delay_if dch ();
    assign dch.cond = cond_s2_q[g];
    assign dch.enable = dly_ok[g];
    // settings above the documented ceiling are clamped
    assign dch.on_delay = (on_delay_s[g*10 +: 10] > aoc_pkg::DELAY_MAX_S) ?
      aoc_pkg::DELAY_MAX_S : on_delay_s[g*10 +: 10];
    assign dch.off_delay = (off_delay_s[g*10 +: 10] > aoc_pkg::DELAY_MAX_S) ?
      aoc_pkg::DELAY_MAX_S : off_delay_s[g*10 +: 10];
    assign delayed[g] = dch.delayed;
    aoc_delay_unit u_dly (
      .clock(clock),
      .rst_n(rst_n_q),
      .tick(tick),
      .ch(dch)
    );
  end

  // cancel sources and level-entry detect; edge so a held key does not block new alarms
  always_comb
  begin
    cancel = (function_key_is_latch_cancel_function && key_s2_q && !key_prev_q)
      || (|(event_is_latch_cancel_function & ev_s2_q & ~ev_prev_q));
    setup_level = (operating_level == aoc_pkg::LVL_INITIAL)
      || (operating_level == aoc_pkg::LVL_COMMS)
      || (operating_level == aoc_pkg::LVL_ADVANCED)
      || (operating_level == aoc_pkg::LVL_CALIBRATION);
    level_entry = setup_level && (operating_level != level_q);
  end

  // latch, state and polarity next values
  always_comb
  begin
    latch_d = latch_q;
    for (int i = 0; i < 4; i++)
    begin
      if (cancel || !hold_ok[i])
        latch_d[i] = 1'b0;
      // capture and hold; a fresh alarm wins over a cancel
      if (hold_ok[i] && delayed[i])
        latch_d[i] = 1'b1;
      // forced off on entering a setup level
      if (level_entry)
        latch_d[i] = 1'b0;
    end
    state_d = setup_level ? 4'h0 : (delayed | latch_d);
    aux_d = state_d ^ open_in_alarm;
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      latch_q <= 4'h0;
      state_q <= 4'h0;
      aux_q <= 4'h0;
      level_q <= aoc_pkg::LVL_OPERATION;
    end
    else
    begin
      latch_q <= latch_d;
      state_q <= state_d;
      aux_q <= aux_d;
      level_q <= operating_level;
    end
  end

  assign aux_out = aux_q;
  assign alarm_state = state_q;

  // ------------------------------------------------------------
  // assertions and covers
  // ------------------------------------------------------------

  property p_hold;
    @(posedge clock) disable iff (!rst_n_q)
    (latch_q[0] && hold_ok[0] && !cancel && !setup_level && !level_entry) |=> latch_q[0];
  endproperty
  a_hold: assert property (p_hold) else $error("held alarm dropped");

  property p_key_cancel;
    @(posedge clock) disable iff (!rst_n_q)
    (function_key_is_latch_cancel_function && key_s2_q && !key_prev_q && !delayed[1])
      |=> !latch_q[1];
  endproperty
  a_key_cancel: assert property (p_key_cancel) else $error("key cancel ignored");

  property p_event_cancel;
    @(posedge clock) disable iff (!rst_n_q)
    ((|(event_is_latch_cancel_function & ev_s2_q & ~ev_prev_q)) && !delayed[2])
      |=> !latch_q[2];
  endproperty
  a_event_cancel: assert property (p_event_cancel) else $error("event cancel ignored");

  property p_reset_clear;
    @(posedge clock) $rose(rst_n_q) |-> (latch_q == 4'h0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("latch set after reset");

  property p_setup_off;
    @(posedge clock) disable iff (!rst_n_q)
    setup_level |=> (alarm_state == 4'h0);
  endproperty
  a_setup_off: assert property (p_setup_off) else $error("output on in setup level");

  property p_polarity;
    @(posedge clock) disable iff (!rst_n_q)
    1'b1 |=> (aux_out == (alarm_state ^ $past(open_in_alarm)));
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity wrong");

  property p_lbr_no_hold;
    @(posedge clock) disable iff (!rst_n_q)
    (alarm_type[9:5] == aoc_pkg::TYPE_LOOP_BREAK) |=> !latch_q[1];
  endproperty
  a_lbr_no_hold: assert property (p_lbr_no_hold) else $error("hold on excluded type");

  property p_no_delay_13;
    @(posedge clock) disable iff (!rst_n_q)
    (alarm_type[9:5] == aoc_pkg::TYPE_EXCLUDED_13 && alarm_assigned[1] && !setup_level
      && cond_s2_q[1]) ##1 !setup_level |=> alarm_state[1];
  endproperty
  a_no_delay_13: assert property (p_no_delay_13) else $error("delay on excluded type");

  property p_unassigned_pass;
    @(posedge clock) disable iff (!rst_n_q)
    (!alarm_assigned[2] && !setup_level && cond_s2_q[2]) ##1 !setup_level |=> alarm_state[2];
  endproperty
  a_unassigned_pass: assert property (p_unassigned_pass) else $error("unassigned delayed");

  property p_entry_clear;
    @(posedge clock) disable iff (!rst_n_q)
    level_entry |=> (latch_q == 4'h0) && (alarm_state == 4'h0);
  endproperty
  a_entry_clear: assert property (p_entry_clear) else $error("latch kept on setup entry");

  property p_held_polarity;
    @(posedge clock) disable iff (!rst_n_q)
    (latch_q[0] && hold_ok[0] && !cancel && !setup_level)
      |=> alarm_state[0] && (aux_out[0] == !$past(open_in_alarm[0]));
  endproperty
  a_held_polarity: assert property (p_held_polarity) else $error("held output moved");

  // alarm 1 keeps its hold on the loop-break code that alarms 2-4 refuse
  property p_first_hold_type;
    @(posedge clock) disable iff (!rst_n_q)
    (alarm_assigned[0] && alarm1_hold_enable && alarm_type[4:0] == aoc_pkg::TYPE_LOOP_BREAK
      && delayed[0] && !setup_level) |=> latch_q[0];
  endproperty
  a_first_hold_type: assert property (p_first_hold_type) else $error("alarm 1 hold lost");

  c_latch_held: cover property (@(posedge clock) latch_q[0] && !cond_s2_q[0]);
  c_key: cover property (@(posedge clock) cancel ##1 latch_q == 4'h0);
  c_setup: cover property (@(posedge clock) level_entry);
endmodule
`default_nettype wire

// ===== dv/alarm_output_conditioner_tb_top.sv
// testbench: self-checking scenarios for the alarm output conditioner top
`default_nettype none
module alarm_output_conditioner_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clock;
  logic rstn;
  logic [3:0] alarm_cond;
  logic [3:0] alarm_assigned;
  logic [19:0] alarm_type;
  logic [3:0] hold_en;
  logic [39:0] on_delay_s;
  logic [39:0] off_delay_s;
  logic [3:0] open_in_alarm;
  logic function_key;
  logic key_cancel_cfg;
  logic [5:0] event_in;
  logic [5:0] event_cancel_cfg;
  logic [2:0] operating_level;
  logic [3:0] aux_out;
  logic [3:0] alarm_state;
  int fails;
  int cmp_count;

  // types used by most scenarios: every alarm set to code 1
  localparam logic [19:0] TYPES_PLAIN = 20'h08421;

  aoc_top DUT (
    .clock(clock),
    .rstn(rstn),
    .alarm_cond(alarm_cond),
    .alarm_assigned(alarm_assigned),
    .alarm_type(alarm_type),
    .alarm1_hold_enable(hold_en[0]),
    .alarm2_hold_enable(hold_en[1]),
    .alarm3_hold_enable(hold_en[2]),
    .alarm4_hold_enable(hold_en[3]),
    .on_delay_s(on_delay_s),
    .off_delay_s(off_delay_s),
    .open_in_alarm(open_in_alarm),
    .function_key(function_key),
    .function_key_is_latch_cancel_function(key_cancel_cfg),
    .event_in(event_in),
    .event_is_latch_cancel_function(event_cancel_cfg),
    .operating_level(operating_level),
    .aux_out(aux_out),
    .alarm_state(alarm_state)
  );

  // 200 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // compares state and the polarity-adjusted output together
  task automatic chk(input logic [3:0] exp, input string msg);
    cmp_count++;
    if (alarm_state !== exp || aux_out !== (exp ^ open_in_alarm))
    begin
      fails++;
      $display("MISMATCH t=%0t %s state=%h aux=%h exp=%h", $time, msg, alarm_state, aux_out, exp);
    end
  endtask

  // bounded wait on the falling edge, where outputs have settled
  task automatic wait_for(input logic [3:0] exp, input int bound, input string msg);
    int n;
    n = 0;
    @(negedge clock);
    while (alarm_state !== exp && n < bound)
    begin
      @(negedge clock);
      n++;
    end
    if (alarm_state !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t timeout waiting in %s", $time, msg);
      wrap_up();
    end
    chk(exp, msg);
    // return on a rising edge so callers drive inputs there
    @(posedge clock);
  endtask

  task automatic hold_for(input logic [3:0] exp, input int n, input string msg);
    repeat (n)
    begin
      @(negedge clock);
      chk(exp, msg);
    end
    @(posedge clock);
  endtask

  task automatic set_cond(input logic [3:0] v);
    @(posedge clock);
    alarm_cond <= v;
  endtask

  // raise every alarm, then drop the conditions so only latches remain
  task automatic arm_latches;
    set_cond(4'hf);
    wait_for(4'hf, 6, "arm");
    set_cond(4'h0);
    repeat (6) @(posedge clock);
  endtask

  // pulse long enough to pass the input synchroniser
  task automatic pulse_key;
    @(posedge clock);
    function_key <= 1'b1;
    repeat (3) @(posedge clock);
    function_key <= 1'b0;
  endtask

  task automatic do_reset;
    @(posedge clock);
    rstn <= 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_pass_through;
    hold_en <= 4'h0;
    set_cond(4'hf);
    wait_for(4'hf, 6, "zero on delay");
    set_cond(4'h0);
    wait_for(4'h0, 6, "zero off delay");
  endtask

  task automatic t_latch_cancel;
    int e;
    hold_en <= 4'hf;
    arm_latches();
    hold_for(4'hf, 20, "latch holds");
    key_cancel_cfg <= 1'b0;
    pulse_key();
    hold_for(4'hf, 8, "key not set to cancel");
    key_cancel_cfg <= 1'b1;
    pulse_key();
    wait_for(4'h0, 8, "key cancel");
    key_cancel_cfg <= 1'b0;
    for (e = 0; e < 6; e++)
    begin
      arm_latches();
      event_cancel_cfg <= 6'h01 << e;
      @(posedge clock);
      event_in <= 6'h01 << e;
      repeat (3) @(posedge clock);
      event_in <= 6'h00;
      wait_for(4'h0, 8, "event cancel");
    end
    event_cancel_cfg <= 6'h00;
    arm_latches();
    do_reset();
    @(negedge clock);
    chk(4'h0, "power cycle clears latch");
    @(posedge clock);
  endtask

  task automatic t_levels;
    int lv;
    hold_en <= 4'hf;
    key_cancel_cfg <= 1'b1;
    for (lv = 0; lv < 6; lv++)
    begin
      arm_latches();
      @(posedge clock);
      operating_level <= 3'(lv);
      if (lv >= 2)
        wait_for(4'h0, 4, "setup level forces off");
      else
        hold_for(4'hf, 8, "run level keeps latch");
      @(posedge clock);
      operating_level <= aoc_pkg::LVL_OPERATION;
      if (lv >= 2)
        hold_for(4'h0, 6, "latch cleared on entry");
      else
      begin
        pulse_key();
        wait_for(4'h0, 8, "key cancel");
      end
    end
    key_cancel_cfg <= 1'b0;
  endtask

  task automatic t_type_gate;
    hold_en <= 4'hf;
    alarm_type <= {5'h01, aoc_pkg::TYPE_NONE, aoc_pkg::TYPE_LOOP_BREAK,
                   aoc_pkg::TYPE_LOOP_BREAK};
    arm_latches();
    wait_for(4'h9, 8, "latch gated by type");
    hold_for(4'h9, 10, "gated latches stay");
    key_cancel_cfg <= 1'b1;
    pulse_key();
    wait_for(4'h0, 8, "key cancel");
    key_cancel_cfg <= 1'b0;
    alarm_type <= TYPES_PLAIN;
  endtask

  // the one-second tick is far beyond the run, so a delay never expires here
  task automatic t_delays;
    hold_en <= 4'h0;
    alarm_assigned <= 4'hb;
    alarm_type <= {5'h01, 5'h01, aoc_pkg::TYPE_EXCLUDED_13, 5'h01};
    on_delay_s <= {10'h000, 10'h005, 10'h005, 10'h005};
    set_cond(4'hf);
    wait_for(4'he, 8, "on delay bypass");
    hold_for(4'he, 300, "on delay holds off");
    set_cond(4'h0);
    wait_for(4'h0, 8, "drop before expiry");
    alarm_assigned <= 4'hf;
    alarm_type <= TYPES_PLAIN;
    on_delay_s <= 40'h0;
    off_delay_s <= {30'h0, 10'h005};
    set_cond(4'h1);
    wait_for(4'h1, 8, "rise with zero on delay");
    set_cond(4'h0);
    hold_for(4'h1, 300, "off delay holds on");
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    fails = 0;
    cmp_count = 0;
    rstn = 1'b0;
    alarm_cond = 4'h0;
    alarm_assigned = 4'hf;
    alarm_type = TYPES_PLAIN;
    hold_en = 4'h0;
    on_delay_s = 40'h0;
    off_delay_s = 40'h0;
    open_in_alarm = 4'h5;
    function_key = 1'b0;
    key_cancel_cfg = 1'b0;
    event_in = 6'h00;
    event_cancel_cfg = 6'h00;
    operating_level = aoc_pkg::LVL_OPERATION;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk(4'h0, "state after reset");
    @(posedge clock);
    t_pass_through();
    t_latch_cancel();
    t_levels();
    t_type_gate();
    t_delays();
    wrap_up();
  end
endmodule
`default_nettype wire
